// ===== pkg/cmx_pkg.sv
// cmx_pkg: constants and types for the compact-instruction
// multiply/divide and control-flow execution block.
// assumes one core clock domain and 64-bit general registers.

package cmx_pkg;

    // ------------------------------------------------------------
    // widths and fields
    // ------------------------------------------------------------
    localparam int DWORD_W = 64;
    localparam int REG_IDX_W = 5;
    localparam int TARGET_W = 26;
    localparam int IMM_SHORT_W = 8;
    localparam int IMM_LONG_W = 11;
    localparam int TARGET_SHIFT = 2;
    localparam int REGION_LSB = 28;
    localparam int HAZARD_DEPTH = 2;

    // ------------------------------------------------------------
    // register indices and reset values
    // ------------------------------------------------------------
    localparam logic [REG_IDX_W-1:0] RETURN_LINK_IDX = 5'h1F;
    localparam logic [REG_IDX_W-1:0] TEST_REG_IDX = 5'h18;
    localparam logic INSTRUCTION_LENGTH_SELECT_RESET = 1'h0;
    localparam logic [63:0] RESULT_RESET = 64'h0000000000000000;

    // ------------------------------------------------------------
    // instruction lengths in bytes
    // ------------------------------------------------------------
    localparam logic [63:0] LEN_SHORT = 64'h0000000000000002;
    localparam logic [63:0] LEN_EXTENDED = 64'h0000000000000004;

    // instruction_length_select encoding
    localparam logic MODE_WORD = 1'h0;
    localparam logic MODE_HALF = 1'h1;

    // ------------------------------------------------------------
    // operations handed to the block
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_OTHER,
        OP_MOVE_FROM_LOW,
        OP_MOVE_FROM_HIGH,
        OP_SIGNED_DWORD_MULTIPLY,
        OP_UNSIGNED_DWORD_MULTIPLY,
        OP_SIGNED_DWORD_DIVIDE,
        OP_UNSIGNED_DWORD_DIVIDE,
        OP_JUMP_WITH_LINK,
        OP_JUMP_LINK_SWITCH_LENGTH,
        OP_JUMP_VIA_REGISTER,
        OP_JUMP_VIA_RETURN_LINK,
        OP_JUMP_VIA_REGISTER_WITH_LINK,
        OP_BRANCH_REG_ZERO,
        OP_BRANCH_REG_NONZERO,
        OP_BRANCH_TEST_ZERO,
        OP_BRANCH_TEST_NONZERO,
        OP_BRANCH_ALWAYS
    } cmx_op_t;

    typedef enum logic {
        JS_IDLE,
        JS_SLOT
    } cmx_jump_state_t;

endpackage

// ===== design/cmx_muldiv.sv
// cmx_muldiv: combinational doubleword multiply and divide.
// assumes 64-bit operands; the caller registers the results.

`timescale 1ns/10ps

module cmx_muldiv
    import cmx_pkg::*;
#(
    parameter int XLEN = DWORD_W
)
(
    // operands
    input wire logic [XLEN-1:0] dividendA,
    input wire logic [XLEN-1:0] divisorB,
    // operation select
    input wire logic isSigned,
    input wire logic isDivide,
    // results
    output logic [XLEN-1:0] resUpper,
    output logic [XLEN-1:0] resLower
);

    if (XLEN != DWORD_W) begin : g_check
        $error("cmx_muldiv serves 64-bit operands only");
    end

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    logic signed [2*XLEN-1:0] prodS;
    logic [2*XLEN-1:0] prodU;
    logic [XLEN-1:0] quotS;
    logic [XLEN-1:0] remS;
    logic [XLEN-1:0] quotU;
    logic [XLEN-1:0] remU;
    logic divZero;

    assign divZero = (divisorB == '0);

    always_comb
    begin
        prodS = $signed({{XLEN{dividendA[XLEN-1]}}, dividendA})
              * $signed({{XLEN{divisorB[XLEN-1]}}, divisorB});
        prodU = {{XLEN{1'b0}}, dividendA}
              * {{XLEN{1'b0}}, divisorB};
        // zero divisor gives a defined but meaningless value
        if (divZero)
        begin
            quotS = '1;
            remS = dividendA;
            quotU = '1;
            remU = dividendA;
        end
        else
        begin
            quotS = XLEN'($signed(dividendA) / $signed(divisorB));
            remS = XLEN'($signed(dividendA) % $signed(divisorB));
            quotU = dividendA / divisorB;
            remU = dividendA % divisorB;
        end
        if (isDivide)
        begin
            resLower = isSigned ? quotS : quotU;
            resUpper = isSigned ? remS : remU;
        end
        else
        begin
            resLower = isSigned ? prodS[XLEN-1:0] : prodU[XLEN-1:0];
            resUpper = isSigned ? prodS[2*XLEN-1:XLEN]
                                : prodU[2*XLEN-1:XLEN];
        end
    end

endmodule

// ===== design/cmx_exec.sv
// cmx_exec: executes compact-instruction doubleword multiply/divide,
// result-register moves, jumps and branches.
// assumes one operation offered per cycle on opValid, operands
// already read from the register file, writes done by the caller.

`timescale 1ns/10ps

module cmx_exec
    import cmx_pkg::*;
#(
    parameter int XLEN = DWORD_W
)
(
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    // operation issue
    input wire logic opValid,
    input cmx_op_t opCode,
    input wire logic [XLEN-1:0] opPc,
    input wire logic [XLEN-1:0] opA,
    input wire logic [XLEN-1:0] opB,
    input wire logic [REG_IDX_W-1:0] opDest,
    input wire logic [TARGET_W-1:0] opTarget,
    input wire logic [IMM_SHORT_W-1:0] opImmShort,
    input wire logic [IMM_LONG_W-1:0] opImmLong,
    input wire logic [XLEN-1:0] testReg,
    // privilege state
    input wire logic mode64,
    input wire logic kernelMode,
    // general register write
    output logic wbValid,
    output logic [REG_IDX_W-1:0] wbIndex,
    output logic [XLEN-1:0] wbData,
    // return link write
    output logic linkValid,
    output logic [REG_IDX_W-1:0] linkIndex,
    output logic [XLEN-1:0] linkData,
    // fetch redirect
    output logic redirectValid,
    output logic [XLEN-1:0] redirectPc,
    output logic squashNext,
    // exceptions and status
    output logic reservedExc,
    output logic addressExc,
    output logic readHazard,
    output logic lengthMode,
    output logic [XLEN-1:0] upperResult,
    output logic [XLEN-1:0] lowerResult
);

    if (XLEN != DWORD_W) begin : g_check
        $error("cmx_exec serves 64-bit registers only");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // pc-relative target from an 11-bit signed offset
    function automatic logic [XLEN-1:0] relTarget(
        input logic [XLEN-1:0] pc,
        input logic [IMM_LONG_W-1:0] imm
    );
        logic [XLEN-1:0] offs;
        offs = {{(XLEN-IMM_LONG_W){imm[IMM_LONG_W-1]}}, imm} << 1;
        return pc + LEN_SHORT + offs;
    endfunction

    // address with its bit zero replaced by a mode bit
    function automatic logic [XLEN-1:0] withMode(
        input logic [XLEN-1:0] addr,
        input logic mode
    );
        return {addr[XLEN-1:1], mode};
    endfunction

    // ------------------------------------------------------------
    // arithmetic unit
    // ------------------------------------------------------------
    logic mdSigned;
    logic mdDivide;
    logic [XLEN-1:0] mdUpper;
    logic [XLEN-1:0] mdLower;

    assign mdSigned = (opCode == OP_SIGNED_DWORD_MULTIPLY)
                   || (opCode == OP_SIGNED_DWORD_DIVIDE);
    assign mdDivide = (opCode == OP_SIGNED_DWORD_DIVIDE)
                   || (opCode == OP_UNSIGNED_DWORD_DIVIDE);

    cmx_muldiv #(
        .XLEN(XLEN)
    ) u_muldiv (
        .dividendA(opA),
        .divisorB(opB),
        .isSigned(mdSigned),
        .isDivide(mdDivide),
        .resUpper(mdUpper),
        .resLower(mdLower)
    );

    // ------------------------------------------------------------
    // decode terms
    // ------------------------------------------------------------
    logic isMulDiv;
    logic isMove;
    logic mdAllowed;
    logic [XLEN-1:0] slotPc;
    logic [XLEN-1:0] afterSlot;
    logic [XLEN-1:0] absTarget;
    logic [IMM_LONG_W-1:0] shortExt;

    assign isMulDiv = (opCode == OP_SIGNED_DWORD_MULTIPLY)
                   || (opCode == OP_UNSIGNED_DWORD_MULTIPLY)
                   || mdDivide;
    assign isMove = (opCode == OP_MOVE_FROM_LOW)
                 || (opCode == OP_MOVE_FROM_HIGH);
    assign mdAllowed = mode64 || kernelMode;
    // extended absolute jumps are four bytes, the rest two
    assign slotPc = opPc + (((opCode == OP_JUMP_WITH_LINK)
                   || (opCode == OP_JUMP_LINK_SWITCH_LENGTH))
                   ? LEN_EXTENDED : LEN_SHORT);
    assign afterSlot = slotPc + LEN_SHORT;
    assign absTarget = {slotPc[XLEN-1:REGION_LSB], opTarget,
                        2'h0};
    assign shortExt = {{(IMM_LONG_W-IMM_SHORT_W)
                        {opImmShort[IMM_SHORT_W-1]}}, opImmShort};

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cmx_jump_state_t jumpState;
    cmx_jump_state_t next_jumpState;
    logic [XLEN-1:0] pendTarget;
    logic [XLEN-1:0] next_pendTarget;
    logic pendMode;
    logic next_pendMode;
    logic [HAZARD_DEPTH-1:0] moveHist;
    logic [HAZARD_DEPTH-1:0] next_moveHist;
    logic next_wbValid;
    logic [REG_IDX_W-1:0] next_wbIndex;
    logic [XLEN-1:0] next_wbData;
    logic next_linkValid;
    logic [XLEN-1:0] next_linkData;
    logic next_redirectValid;
    logic [XLEN-1:0] next_redirectPc;
    logic next_squashNext;
    logic next_reservedExc;
    logic next_addressExc;
    logic next_readHazard;
    logic next_lengthMode;
    logic [XLEN-1:0] next_upperResult;
    logic [XLEN-1:0] next_lowerResult;
    logic brTaken;

    assign linkIndex = RETURN_LINK_IDX;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_jumpState = jumpState;
        next_pendTarget = pendTarget;
        next_pendMode = pendMode;
        next_moveHist = moveHist;
        next_wbValid = 1'b0;
        next_wbIndex = wbIndex;
        next_wbData = wbData;
        next_linkValid = 1'b0;
        next_linkData = linkData;
        next_redirectValid = 1'b0;
        next_redirectPc = redirectPc;
        next_squashNext = 1'b0;
        next_reservedExc = 1'b0;
        next_addressExc = 1'b0;
        next_readHazard = 1'b0;
        next_lengthMode = lengthMode;
        next_upperResult = upperResult;
        next_lowerResult = lowerResult;
        brTaken = 1'b0;
        if (opValid)
        begin
            next_moveHist = {moveHist[HAZARD_DEPTH-2:0], isMove};
            // this op is the delay slot: it runs, then control moves
            if (jumpState == JS_SLOT)
            begin
                next_jumpState = JS_IDLE;
                next_redirectValid = 1'b1;
                next_lengthMode = pendMode;
                if (pendMode == MODE_HALF)
                begin
                    next_redirectPc = withMode(pendTarget, 1'b0);
                end
                else
                begin
                    next_redirectPc = pendTarget;
                    next_addressExc = (pendTarget[1:0] != 2'h0);
                end
            end
            case (opCode)
                OP_MOVE_FROM_LOW:
                begin
                    next_wbValid = 1'b1;
                    next_wbIndex = opDest;
                    next_wbData = lowerResult;
                end
                OP_MOVE_FROM_HIGH:
                begin
                    next_wbValid = 1'b1;
                    next_wbIndex = opDest;
                    next_wbData = upperResult;
                end
                OP_SIGNED_DWORD_MULTIPLY,
                OP_UNSIGNED_DWORD_MULTIPLY,
                OP_SIGNED_DWORD_DIVIDE,
                OP_UNSIGNED_DWORD_DIVIDE:
                begin
                    // flags a read made undefined by the spacing rule
                    next_readHazard = mdAllowed && |moveHist;
                    if (mdAllowed)
                    begin
                        next_upperResult = mdUpper;
                        next_lowerResult = mdLower;
                    end
                    else
                    begin
                        next_reservedExc = 1'b1;
                    end
                end
                OP_JUMP_WITH_LINK,
                OP_JUMP_LINK_SWITCH_LENGTH:
                begin
                    if (jumpState == JS_IDLE)
                    begin
                        next_jumpState = JS_SLOT;
                        next_pendTarget = absTarget;
                        next_pendMode = (opCode == OP_JUMP_WITH_LINK)
                                      ? lengthMode : ~lengthMode;
                        next_linkValid = 1'b1;
                        next_linkData = withMode(afterSlot, lengthMode);
                    end
                end
                OP_JUMP_VIA_REGISTER,
                OP_JUMP_VIA_RETURN_LINK,
                OP_JUMP_VIA_REGISTER_WITH_LINK:
                begin
                    if (jumpState == JS_IDLE)
                    begin
                        next_jumpState = JS_SLOT;
                        next_pendTarget = opA;
                        next_pendMode = opA[0];
                        if (opCode == OP_JUMP_VIA_REGISTER_WITH_LINK)
                        begin
                            next_linkValid = 1'b1;
                            next_linkData = withMode(afterSlot, lengthMode);
                        end
                    end
                end
                OP_BRANCH_REG_ZERO,
                OP_BRANCH_REG_NONZERO,
                OP_BRANCH_TEST_ZERO,
                OP_BRANCH_TEST_NONZERO,
                OP_BRANCH_ALWAYS:
                begin
                    case (opCode)
                        OP_BRANCH_REG_ZERO: brTaken = (opA == '0);
                        OP_BRANCH_REG_NONZERO: brTaken = (opA != '0);
                        OP_BRANCH_TEST_ZERO:
                            brTaken = (testReg == '0);
                        OP_BRANCH_TEST_NONZERO: brTaken = (testReg != '0);
                        default: brTaken = 1'b1;
                    endcase
                    // a branch sitting in a delay slot is not acted on
                    if (brTaken && (jumpState == JS_IDLE))
                    begin
                        next_redirectValid = 1'b1;
                        next_squashNext = 1'b1;
                        next_redirectPc = relTarget(opPc,
                            (opCode == OP_BRANCH_ALWAYS)
                            ? opImmLong : shortExt);
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            jumpState <= JS_IDLE;
            pendTarget <= RESULT_RESET;
            pendMode <= INSTRUCTION_LENGTH_SELECT_RESET;
            moveHist <= '0;
            wbValid <= 1'b0;
            wbIndex <= '0;
            wbData <= RESULT_RESET;
            linkValid <= 1'b0;
            linkData <= RESULT_RESET;
            redirectValid <= 1'b0;
            redirectPc <= RESULT_RESET;
            squashNext <= 1'b0;
            reservedExc <= 1'b0;
            addressExc <= 1'b0;
            readHazard <= 1'b0;
            lengthMode <= INSTRUCTION_LENGTH_SELECT_RESET;
            upperResult <= RESULT_RESET;
            lowerResult <= RESULT_RESET;
        end
        else if (clkEn)
        begin
            jumpState <= next_jumpState;
            pendTarget <= next_pendTarget;
            pendMode <= next_pendMode;
            moveHist <= next_moveHist;
            wbValid <= next_wbValid;
            wbIndex <= next_wbIndex;
            wbData <= next_wbData;
            linkValid <= next_linkValid;
            linkData <= next_linkData;
            redirectValid <= next_redirectValid;
            redirectPc <= next_redirectPc;
            squashNext <= next_squashNext;
            reservedExc <= next_reservedExc;
            addressExc <= next_addressExc;
            readHazard <= next_readHazard;
            lengthMode <= next_lengthMode;
            upperResult <= next_upperResult;
            lowerResult <= next_lowerResult;
        end
    end

endmodule

// ===== verification/cmx_exec_asserts.sv
// cmx_exec_asserts: port-level checks for the execution block.
// assumes one clock domain; bound to cmx_exec below.
`timescale 1ns/10ps

module cmx_exec_asserts
    import cmx_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // issue side
    input wire logic clkEn,
    input wire logic opValid,
    input cmx_op_t opCode,
    input wire logic [DWORD_W-1:0] opPc,
    input wire logic [DWORD_W-1:0] opA,
    input wire logic [IMM_LONG_W-1:0] opImmLong,
    input wire logic mode64,
    input wire logic kernelMode,
    // result side
    input wire logic wbValid,
    input wire logic [DWORD_W-1:0] wbData,
    input wire logic linkValid,
    input wire logic [DWORD_W-1:0] linkData,
    input wire logic redirectValid,
    input wire logic [DWORD_W-1:0] redirectPc,
    input wire logic squashNext,
    input wire logic reservedExc,
    input wire logic addressExc,
    input wire logic lengthMode,
    input wire logic [DWORD_W-1:0] upperResult,
    input wire logic [DWORD_W-1:0] lowerResult
);
    logic take, isMd, isJmp, inSlot, next_inSlot;

    // ----------------------------------------------------------
    // delay slot tracking
    // ----------------------------------------------------------
    assign take = clkEn && opValid;
    assign isMd = opCode inside {OP_SIGNED_DWORD_MULTIPLY,
        OP_UNSIGNED_DWORD_MULTIPLY, OP_SIGNED_DWORD_DIVIDE,
        OP_UNSIGNED_DWORD_DIVIDE};
    assign isJmp = opCode inside {OP_JUMP_WITH_LINK,
        OP_JUMP_LINK_SWITCH_LENGTH, OP_JUMP_VIA_REGISTER,
        OP_JUMP_VIA_RETURN_LINK, OP_JUMP_VIA_REGISTER_WITH_LINK};

    always_comb
    begin
        next_inSlot = inSlot;
        if (take)
            next_inSlot = isJmp && !inSlot;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            inSlot <= 1'b0;
        else
            inSlot <= next_inSlot;
    end

    // ----------------------------------------------------------
    // properties
    // ----------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_MOVE_LOW:
    assert property (take && opCode == OP_MOVE_FROM_LOW |=> wbValid
        && wbData == $past(lowerResult)) else $error("low move data");
    AST_MOVE_HIGH:
    assert property (take && opCode == OP_MOVE_FROM_HIGH |=> wbValid
        && wbData == $past(upperResult)) else $error("high move data");
    AST_RESV:
    assert property (take && isMd && !mode64 && !kernelMode |=> reservedExc
        && $stable(upperResult) && $stable(lowerResult))
        else $error("mul/div not refused");
    AST_HOLD:
    assert property (!(take && isMd) |=> $stable(upperResult)
        && $stable(lowerResult)) else $error("result changed");
    AST_JMP_QUIET:
    assert property (take && isJmp && !inSlot |=> !redirectValid)
        else $error("jump redirected early");
    AST_SLOT_REDIR:
    assert property (take && inSlot |=> redirectValid && !squashNext)
        else $error("jump redirect after slot");
    AST_SQUASH:
    assert property (squashNext |-> redirectValid)
        else $error("squash without redirect");
    AST_BR_ZERO:
    assert property (take && !inSlot && opCode == OP_BRANCH_REG_ZERO |=>
        (redirectValid && squashNext) == ($past(opA) == 64'h0))
        else $error("zero branch decision");
    AST_BR_ALWAYS:
    assert property (take && !inSlot && opCode == OP_BRANCH_ALWAYS |=>
        redirectValid && redirectPc == $past(opPc) + 64'h2
        + {{52{$past(opImmLong[10])}}, $past(opImmLong), 1'b0})
        else $error("always branch target");
    AST_LINK:
    assert property (take && !inSlot && opCode == OP_JUMP_WITH_LINK |=>
        linkValid && linkData == (($past(opPc) + 64'h6) & ~64'h1
        | {63'h0, $past(lengthMode)})) else $error("link value");
    AST_ADDR_EXC:
    assert property (addressExc |-> redirectValid && !lengthMode
        && redirectPc[1:0] != 2'h0) else $error("address fault cause");
    AST_HALF_EVEN:
    assert property (redirectValid && lengthMode |-> !redirectPc[0])
        else $error("odd half-mode target");
endmodule

bind cmx_exec cmx_exec_asserts u_chk (
    .clk_sys, .rst_n, .clkEn, .opValid, .opCode, .opPc, .opA, .opImmLong,
    .mode64, .kernelMode, .wbValid, .wbData, .linkValid, .linkData,
    .redirectValid, .redirectPc, .squashNext, .reservedExc, .addressExc,
    .lengthMode, .upperResult, .lowerResult
);

// ===== verification/tb.sv
// tb: self-checking bench for cmx_exec.
// assumes the checker binds itself from its own file.
`timescale 1ns/10ps

module tb
    import cmx_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic opValid = 1'b0;
    cmx_op_t opCode = OP_OTHER;
    logic [63:0] opPc = 64'h0, opA = 64'h0, opB = 64'h0, testReg = 64'h0;
    logic [4:0] opDest = 5'h07;
    logic [25:0] opTarget = 26'h1234567;
    logic [7:0] opImmShort = 8'h80;
    logic [10:0] opImmLong = 11'h400;
    logic mode64 = 1'b1, kernelMode = 1'b0;
    logic wbValid, linkValid, redirectValid, squashNext, lengthMode;
    logic reservedExc, addressExc, readHazard;
    logic [4:0] wbIndex, linkIndex;
    logic [63:0] wbData, linkData, redirectPc, upperResult, lowerResult;
    logic [63:0] expHi, expLo;
    logic curMode = 1'b0;
    int err_total = 0;
    int n_compared = 0;

    cmx_exec uut (.clk_sys, .rst_n, .clkEn, .opValid, .opCode, .opPc, .opA,
        .opB, .opDest, .opTarget, .opImmShort, .opImmLong, .testReg,
        .mode64, .kernelMode, .wbValid, .wbIndex, .wbData, .linkValid,
        .linkIndex, .linkData, .redirectValid, .redirectPc, .squashNext,
        .reservedExc, .addressExc, .readHazard, .lengthMode, .upperResult,
        .lowerResult);

    initial
        forever #2 clk_sys = ~clk_sys;

    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic check(input string nm, input logic [63:0] seen,
        input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one op taken at the next edge; returns with its outputs settled
    task automatic issue(input cmx_op_t op, input logic [63:0] pc,
        input logic [63:0] a);
        opValid = 1'b1;
        opCode = op;
        opPc = pc;
        opA = a;
        @(posedge clk_sys);
        #1;
    endtask

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_muldiv(input logic [63:0] a, input logic [63:0] b);
        logic [127:0] p;
        for (int i = 3; i <= 6; i++)
        begin
            case (i)
                3: p = {{64{a[63]}}, a} * {{64{b[63]}}, b};
                4: p = {64'h0, a} * {64'h0, b};
                5: p = {$signed(a) % $signed(b), $signed(a) / $signed(b)};
                default: p = {a % b, a / b};
            endcase
            opB = b;
            issue(cmx_op_t'(i), 64'h0, a);
            check("upper", upperResult, p[127:64]);
            check("lower", lowerResult, p[63:0]);
        end
        expHi = p[127:64];
        expLo = p[63:0];
        issue(OP_MOVE_FROM_HIGH, 64'h0, 64'h0);
        check("wbIndex", wbIndex, 5'h07);
        check("wbHigh", wbData, expHi);
        issue(OP_MOVE_FROM_LOW, 64'h0, 64'h0);
        check("wbLow", wbData, expLo);
    endtask

    task automatic t_priv();
        mode64 = 1'b0;
        issue(OP_OTHER, 64'h0, 64'h0);
        issue(OP_OTHER, 64'h0, 64'h0);
        opB = 64'h3;
        issue(OP_UNSIGNED_DWORD_MULTIPLY, 64'h0, 64'h2);
        check("resv", reservedExc, 1'b1);
        check("keptLow", lowerResult, expLo);
        kernelMode = 1'b1;
        issue(OP_UNSIGNED_DWORD_MULTIPLY, 64'h0, 64'h2);
        check("kernelResv", reservedExc, 1'b0);
        check("kernelLow", lowerResult, 64'h6);
        clkEn = 1'b0;
        issue(OP_SIGNED_DWORD_DIVIDE, 64'h0, 64'h9);
        check("frozenLow", lowerResult, 64'h6);
        clkEn = 1'b1;
        mode64 = 1'b1;
        kernelMode = 1'b0;
    endtask

    task automatic t_hazard(input int gap);
        issue(OP_MOVE_FROM_LOW, 64'h0, 64'h0);
        repeat (gap) issue(OP_OTHER, 64'h0, 64'h0);
        issue(OP_SIGNED_DWORD_MULTIPLY, 64'h0, 64'h2);
        check("hazard", readHazard, gap < 2);
    endtask

    task automatic t_jlink(input cmx_op_t op);
        logic [63:0] p;
        p = 64'h1FFFFFFC;
        issue(op, p, 64'h0);
        check("link", linkValid, 1'b1);
        check("linkData", linkData,
            (p + 64'h6) & ~64'h1 | {63'h0, curMode});
        check("linkIdx", linkIndex, RETURN_LINK_IDX);
        check("early", redirectValid, 1'b0);
        check("oldMode", lengthMode, curMode);
        issue(OP_OTHER, p + 64'h4, 64'h0);
        if (op == OP_JUMP_LINK_SWITCH_LENGTH)
            curMode = ~curMode;
        check("redirect", redirectValid, 1'b1);
        check("target", redirectPc, ((p + 64'h4) & 64'hFFFFFFFFF0000000)
            | {36'h0, opTarget, 2'h0});
        check("newMode", lengthMode, curMode);
    endtask

    task automatic t_jreg(input cmx_op_t op, input logic [63:0] x);
        logic lk;
        lk = (op == OP_JUMP_VIA_REGISTER_WITH_LINK);
        issue(op, 64'h4000, x);
        check("regLink", linkValid, lk);
        if (lk)
            check("regLinkData", linkData,
                64'h4004 | {63'h0, curMode});
        issue(OP_OTHER, 64'h4002, 64'h0);
        curMode = x[0];
        check("regRedirect", redirectValid, 1'b1);
        check("regTarget", redirectPc, x & ~64'h1);
        check("regMode", lengthMode, curMode);
        check("addrExc", addressExc, !x[0] && x[1]);
    endtask

    task automatic t_branch(input cmx_op_t op, input logic [63:0] v);
        logic tst, tk;
        tst = op inside {OP_BRANCH_TEST_ZERO, OP_BRANCH_TEST_NONZERO};
        tk = (op == OP_BRANCH_ALWAYS) || ((v == 64'h0)
            == (op inside {OP_BRANCH_REG_ZERO, OP_BRANCH_TEST_ZERO}));
        testReg = v;
        issue(op, 64'h1000, tst ? ~v : v);
        check("taken", redirectValid, tk);
        check("squash", squashNext, tk);
        if (tk && op == OP_BRANCH_ALWAYS)
            check("longTarget", redirectPc, 64'h1002 - 64'h800);
        else if (tk)
            check("shortTarget", redirectPc,
                64'h1002 - 64'h100);
    endtask

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_sys);
        #1;
        check("rstMode", lengthMode, INSTRUCTION_LENGTH_SELECT_RESET);
        check("rstLow", lowerResult, RESULT_RESET);
        rst_n = 1'b1;
        t_muldiv(64'hFFFFFFFFFFFFFFFD, 64'h5);
        t_muldiv(64'hF123456789ABCDEF, 64'h00000000FEDCBA98);
        t_priv();
        for (int g = 0; g < 3; g++)
            t_hazard(g);
        t_jlink(OP_JUMP_WITH_LINK);
        t_jlink(OP_JUMP_LINK_SWITCH_LENGTH);
        t_jlink(OP_JUMP_LINK_SWITCH_LENGTH);
        t_jreg(OP_JUMP_VIA_REGISTER, 64'h8001);
        t_jreg(OP_JUMP_VIA_REGISTER_WITH_LINK, 64'h8002);
        t_jreg(OP_JUMP_VIA_RETURN_LINK, 64'h8004);
        for (int k = 12; k <= 16; k++)
        begin
            t_branch(cmx_op_t'(k), 64'h0);
            t_branch(cmx_op_t'(k), 64'h8000000000000000);
        end
        opValid = 1'b0;
        repeat (2) @(posedge clk_sys);
        end_sim();
    end

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        end_sim();
    end
endmodule
